// >>> core/rxs_status_regs.sv
// Receive status, buffer fill and target event registers.
// Assumes event inputs come from logic on clk_sys and the host port
// follows the one-cycle strobe protocol.
//
// Notes on behaviour
// - Reading the target event register clears all its flags except those set in the same cycle.
// - Slot water level flag, bit 6, rises when four free slots remain.
// - Field-on flag, bit 5, rises after clean avoidance with own field on.
// - Bit 4 rises at frame end when target replied on its own.
// - Bit 3 rises after the automatic high-rate polling reply.
// - Bit 1 rises on entering the type-A starred active state.
// - Bit 0 rises on entering the type-A plain active state.
// - Bit 7 rises when the second field-on wait timer expires.
// - Buffer occupancy is a 10-bit byte count from 0 to 512.
// - Low count byte at first buffer register, top two bits at 7:6.
// - Bits 3:1 give final partial byte size; bits sit LSB aligned.
// - Missing-parity flag set when full last byte lacked parity.
// - Under hard framing error, last-byte and collision fields are invalid.
// - Collision bits 7:4 count full bytes before first collision.
// - Collision bits 3:1 count bits of colliding byte before it.
// - Collision bit 0 set only when first collision hits parity.
// - Collision register updates only for type-A anticollision frames.
// - Error register bit 4 flags a corrupting framing error.
// - A set mask bit keeps its event off the interrupt output.
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "rxs_defines.svh"

module rxs_status_regs #(
    parameter int BUF_DEPTH = `RXS_BUF_DEPTH,   // Buffer capacity in bytes
    parameter int SLOT_W    = 5                 // Width of free-slot count
) (
    input  wire logic                clk_sys,         // System clock
    input  wire logic                srst,            // Sync reset, high
    input  wire logic [7:0]          reg_addr,        // Register address
    input  wire logic [7:0]          reg_wdata,       // Write data
    input  wire logic                reg_wr,          // Write strobe
    input  wire logic                reg_rd,          // Read strobe
    output logic      [7:0]          reg_rdata,       // Read data, next cycle
    input  wire rxs_pkg::rxs_evt_type evt,            // Target event inputs
    input  wire logic [SLOT_W-1:0]   slots_free,      // Unused slot numbers
    input  wire logic [3:0]          pta_state,       // Type-A target state
    input  wire logic                buf_push,        // Byte into buffer
    input  wire logic                buf_pop,         // Byte out of buffer
    input  wire logic                buf_clear,       // Empty the buffer
    input  wire rxs_pkg::rxs_rx_type rx,              // Framer results
    input  wire rxs_pkg::rxs_col_type col,            // Collision report
    output logic                     target_irq,      // Masked event request
    output logic      [7:0]          last_byte_aligned, // Last byte, LSB aligned
    output logic                     hard_framing_error // Error flag level
);

    //------------------------------------------------------------------
    // Event detection
    //------------------------------------------------------------------
    logic [7:0]        flags_q;
    logic [7:0]        flags_d;
    logic [7:0]        evt_set;
    logic [7:0]        mask_q;
    logic [SLOT_W-1:0] slots_q;
    logic [3:0]        pta_q;
    logic              evt_read;
    logic              irq_q;

    assign evt_read = reg_rd && (reg_addr == `RXS_OFS_TARGET_EVENT);

    always_comb begin
        evt_set = `RXS_RST_BYTE;
        evt_set[`RXS_EVT_FIELD_WAIT] = evt.field_wait_timer_event;
        evt_set[`RXS_EVT_SLOT_WL] = (slots_free == SLOT_W'(`RXS_SLOT_WL_LEVEL))
                                    && (slots_q != SLOT_W'(`RXS_SLOT_WL_LEVEL));
        evt_set[`RXS_EVT_FIELD_ON] = evt.ca_done && !evt.ca_collision
                                     && evt.own_field_on;
        evt_set[`RXS_EVT_RX_END_REPLY] = rx.done && evt.passive_target_mode
                                         && evt.auto_response_sent;
        evt_set[`RXS_EVT_HIGH_RATE] = evt.high_rate_target_active_event;
        evt_set[`RXS_EVT_ACTIVE_STAR] = (pta_state == `RXS_PTA_ACTIVE_STAR)
                                        && (pta_q != `RXS_PTA_ACTIVE_STAR);
        evt_set[`RXS_EVT_ACTIVE] = (pta_state == `RXS_PTA_ACTIVE)
                                   && (pta_q != `RXS_PTA_ACTIVE);
    end

    // Set wins over the clear caused by a read in the same cycle
    always_comb begin
        flags_d = evt_read ? evt_set : (flags_q | evt_set);
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            slots_q <= SLOT_W'(`RXS_RST_BYTE);
            pta_q   <= 4'h0;
        end else begin
            slots_q <= slots_free;
            pta_q   <= pta_state;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            flags_q <= `RXS_RST_BYTE;
        end else begin
            flags_q <= flags_d;
        end
    end

    //------------------------------------------------------------------
    // Mask and interrupt
    //------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            mask_q <= `RXS_RST_BYTE;
        end else if (reg_wr && (reg_addr == `RXS_OFS_EVENT_MASK)) begin
            mask_q <= reg_wdata & `RXS_EVT_USED_MASK;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(flags_d & ~mask_q);
        end
    end

    assign target_irq = irq_q;

    //------------------------------------------------------------------
    // Buffer fill count
    //------------------------------------------------------------------
    logic [9:0] count_q;
    logic       unf_q;
    logic       ovr_q;
    logic       buf_empty;
    logic       buf_full;
    logic       do_push;
    logic       do_pop;

    assign buf_empty = (count_q == 10'h000);
    assign buf_full  = (count_q == 10'(BUF_DEPTH));
    assign do_push   = buf_push && (!buf_full || buf_pop);
    assign do_pop    = buf_pop && !buf_empty;

    always_ff @(posedge clk_sys) begin
        if (srst || buf_clear) begin
            count_q <= 10'h000;
        end else if (do_push && !do_pop) begin
            count_q <= count_q + 10'h001;
        end else if (do_pop && !do_push) begin
            count_q <= count_q - 10'h001;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst || buf_clear) begin
            unf_q <= 1'b0;
            ovr_q <= 1'b0;
        end else begin
            unf_q <= unf_q || (buf_pop && buf_empty);
            ovr_q <= ovr_q || (buf_push && buf_full && !buf_pop);
        end
    end

    //------------------------------------------------------------------
    // Last byte and framing error
    //------------------------------------------------------------------
    logic [2:0] lb_bits_q;
    logic       np_q;
    logic [7:0] aligned_q;
    logic       err_q;
    logic       err_read;
    logic [7:0] aligned_d;

    assign err_read = reg_rd && (reg_addr == `RXS_OFS_ERROR);

    always_comb begin
        if (rx.last_bits == 3'h0) begin
            aligned_d = rx.last_raw;
        end else begin
            aligned_d = rx.last_raw >> (4'h8 - {1'b0, rx.last_bits});
        end
    end

    // Values latched here are meaningless while the error flag is set
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            lb_bits_q <= 3'h0;
            np_q      <= 1'b0;
            aligned_q <= `RXS_RST_BYTE;
        end else if (rx.done) begin
            lb_bits_q <= rx.last_bits;
            np_q      <= rx.no_parity && (rx.last_bits == 3'h0);
            aligned_q <= aligned_d;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            err_q <= 1'b0;
        end else if (rx.hard_framing_error) begin
            err_q <= 1'b1;
        end else if (err_read) begin
            err_q <= 1'b0;
        end
    end

    assign last_byte_aligned  = aligned_q;
    assign hard_framing_error = err_q;

    //------------------------------------------------------------------
    // Collision position
    //------------------------------------------------------------------
    logic [7:0] col_q;
    logic       col_seen_q;
    logic       col_take;

    assign col_take = col.valid && col.anticoll_frame && !col_seen_q;

    always_ff @(posedge clk_sys) begin
        if (srst || rx.start) begin
            col_seen_q <= 1'b0;
        end else if (col.valid) begin
            col_seen_q <= 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            col_q <= `RXS_RST_BYTE;
        end else if (col_take) begin
            col_q[7:4] <= col.full_bytes;
            col_q[3:1] <= col.bits_before;
            col_q[0]   <= col.on_parity;
        end
    end

    //------------------------------------------------------------------
    // Read port
    //------------------------------------------------------------------
    logic [7:0] rdata_q;
    logic [7:0] rd_mux;

    always_comb begin
        unique case (reg_addr)
            `RXS_OFS_TARGET_EVENT: rd_mux = flags_q;
            `RXS_OFS_BUF_LOW:      rd_mux = count_q[7:0];
            `RXS_OFS_BUF_HIGH:     rd_mux = {count_q[9:8], unf_q, ovr_q,
                                             lb_bits_q, np_q};
            `RXS_OFS_COLLISION:    rd_mux = col_q;
            `RXS_OFS_EVENT_MASK:   rd_mux = mask_q;
            `RXS_OFS_ERROR:        rd_mux = {3'h0, err_q, 4'h0};
            default:               rd_mux = `RXS_RST_BYTE;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            rdata_q <= `RXS_RST_BYTE;
        end else begin
            rdata_q <= reg_rd ? rd_mux : `RXS_RST_BYTE;
        end
    end

    assign reg_rdata = rdata_q;

    //------------------------------------------------------------------
    // Assertions
    //------------------------------------------------------------------
    AST_CLEAR_ON_READ: assert property (@(posedge clk_sys) disable iff (srst)
        (evt_read && (evt_set == 8'h00)) |=> (flags_q == 8'h00))
        else $error("event flags not cleared by read");

    AST_READ_RETURNS_FLAGS: assert property (@(posedge clk_sys) disable iff (srst)
        evt_read |=> (reg_rdata == $past(flags_q)))
        else $error("event read data wrong");

    AST_SLOT_LEVEL: assert property (@(posedge clk_sys) disable iff (srst)
        ((slots_free == SLOT_W'(4)) && !$stable(slots_free))
        |=> flags_q[`RXS_EVT_SLOT_WL])
        else $error("slot water level flag missing");

    AST_FIELD_ON: assert property (@(posedge clk_sys) disable iff (srst)
        (evt.ca_done && !evt.ca_collision && evt.own_field_on) |=> flags_q[5])
        else $error("field-on flag missing");

    AST_NO_FIELD_ON_COLL: assert property (@(posedge clk_sys) disable iff (srst)
        (!flags_q[5] && !evt_read && evt.ca_collision) |=> !flags_q[5])
        else $error("field-on flag set despite collision");

    AST_RXE_PTA: assert property (@(posedge clk_sys) disable iff (srst)
        (rx.done && evt.passive_target_mode && evt.auto_response_sent) |=> flags_q[4])
        else $error("end of receive target flag missing");

    AST_HIGH_RATE: assert property (@(posedge clk_sys) disable iff (srst)
        evt.high_rate_target_active_event |=> flags_q[3])
        else $error("high rate active flag missing");

    AST_ACTIVE_STAR: assert property (@(posedge clk_sys) disable iff (srst)
        ((pta_state == 4'hD) && ($past(pta_state) != 4'hD)) |=> flags_q[1])
        else $error("starred active flag missing");

    AST_ACTIVE: assert property (@(posedge clk_sys) disable iff (srst)
        ((pta_state == 4'h5) && ($past(pta_state) != 4'h5)) |=> flags_q[0])
        else $error("active flag missing");

    AST_FIELD_WAIT: assert property (@(posedge clk_sys) disable iff (srst)
        evt.field_wait_timer_event |=> flags_q[7])
        else $error("field wait timer flag missing");

    AST_RFU_ZERO: assert property (@(posedge clk_sys) disable iff (srst)
        !flags_q[2])
        else $error("reserved event bit set");

    AST_COUNT_RANGE: assert property (@(posedge clk_sys) disable iff (srst)
        count_q <= 10'd512)
        else $error("buffer count beyond 512");

    AST_COUNT_STEP: assert property (@(posedge clk_sys) disable iff (srst)
        (buf_push && !buf_pop && !buf_clear && (count_q < 10'd512))
        |=> (count_q == $past(count_q) + 10'd1))
        else $error("buffer count did not advance");

    AST_HIGH_SPLIT: assert property (@(posedge clk_sys) disable iff (srst)
        (reg_rd && (reg_addr == 8'h1F)) |=> (reg_rdata[7:6] == $past(count_q[9:8])))
        else $error("count high bits misplaced");

    AST_LOW_SPLIT: assert property (@(posedge clk_sys) disable iff (srst)
        (reg_rd && (reg_addr == 8'h1E)) |=> (reg_rdata == $past(count_q[7:0])))
        else $error("count low byte wrong");

    AST_UNDERFLOW: assert property (@(posedge clk_sys) disable iff (srst)
        (buf_pop && (count_q == 10'd0) && !buf_clear) |=> unf_q)
        else $error("underflow not flagged");

    AST_OVERFLOW: assert property (@(posedge clk_sys) disable iff (srst)
        (buf_push && !buf_pop && (count_q == 10'd512) && !buf_clear)
        |=> (ovr_q && (count_q == 10'd512)))
        else $error("overflow not flagged");

    AST_LAST_BITS: assert property (@(posedge clk_sys) disable iff (srst)
        rx.done |=> (lb_bits_q == $past(rx.last_bits)))
        else $error("last byte bit count not latched");

    AST_ALIGN_TOP: assert property (@(posedge clk_sys) disable iff (srst)
        (rx.done && (rx.last_bits != 3'd0))
        |=> ((last_byte_aligned >> lb_bits_q) == 8'h00))
        else $error("partial byte not LSB aligned");

    AST_NO_PARITY: assert property (@(posedge clk_sys) disable iff (srst)
        (rx.done && rx.no_parity && (rx.last_bits == 3'd0)) |=> np_q)
        else $error("missing parity not flagged");

    AST_HARD_ERR: assert property (@(posedge clk_sys) disable iff (srst)
        (rx.hard_framing_error ##1 !err_read) |-> hard_framing_error [*2])
        else $error("hard framing error not held");

    AST_COL_FIELDS: assert property (@(posedge clk_sys) disable iff (srst)
        col_take |=> (col_q == {$past(col.full_bytes), $past(col.bits_before),
                                $past(col.on_parity)}))
        else $error("collision fields not recorded");

    AST_COL_FIRST: assert property (@(posedge clk_sys) disable iff (srst)
        (col.valid && col_seen_q && !rx.start) |=> $stable(col_q))
        else $error("later collision overwrote first");

    AST_COL_LONG_MSG: assert property (@(posedge clk_sys) disable iff (srst)
        (col.valid && !col.anticoll_frame) |=> $stable(col_q))
        else $error("collision register set for long message");

    AST_MASK_GATES: assert property (@(posedge clk_sys) disable iff (srst)
        ((flags_q & ~mask_q) == 8'h00) && $stable(flags_q) && $stable(mask_q)
        |-> !target_irq)
        else $error("masked event drove interrupt");

endmodule // rxs_status_regs
`default_nettype wire

// >>> core/rxs_defines.svh
// Constants of the receive status and event register bank.
// Assumes inclusion by bare name from the bank module only.
`ifndef RXS_DEFINES_SVH
`define RXS_DEFINES_SVH

// Register byte offsets
`define RXS_OFS_TARGET_EVENT   8'h1D
`define RXS_OFS_BUF_LOW        8'h1E
`define RXS_OFS_BUF_HIGH       8'h1F
`define RXS_OFS_COLLISION      8'h20
`define RXS_OFS_EVENT_MASK     8'h30
`define RXS_OFS_ERROR          8'h31

// Target event bit positions
`define RXS_EVT_FIELD_WAIT     7
`define RXS_EVT_SLOT_WL        6
`define RXS_EVT_FIELD_ON       5
`define RXS_EVT_RX_END_REPLY   4
`define RXS_EVT_HIGH_RATE      3
`define RXS_EVT_ACTIVE_STAR    1
`define RXS_EVT_ACTIVE         0
`define RXS_EVT_USED_MASK      8'hFB

// Error register bit position
`define RXS_ERR_HARD_FRAMING   4

// Buffer high register fields
`define RXS_BUF_UNF_BIT        5
`define RXS_BUF_OVR_BIT        4

// Slot water level and type-A target state codes
`define RXS_SLOT_WL_LEVEL      5'h04
`define RXS_PTA_ACTIVE         4'h5
`define RXS_PTA_ACTIVE_STAR    4'hD

// Reset value and buffer depth
`define RXS_RST_BYTE           8'h00
`define RXS_BUF_DEPTH          512

`endif

// >>> core/rxs_pkg.sv
// Types shared by the receive status register bank.
// Assumes the defines header sits on the include path.
package rxs_pkg;

    // Event pulses from the target and collision avoidance logic
    typedef struct packed {
        logic field_wait_timer_event;   // Second field-on interval expired
        logic ca_done;                  // Collision avoidance finished
        logic ca_collision;             // Collision seen during avoidance
        logic own_field_on;             // Own field switched on
        logic passive_target_mode;      // Passive target mode active
        logic auto_response_sent;       // Anticollision or polling reply sent
        logic high_rate_target_active_event; // Polling reply sent at high rate
    } rxs_evt_type;

    // Receive framer results at end of frame
    typedef struct packed {
        logic       start;              // Frame start pulse
        logic       done;               // Frame end pulse
        logic [2:0] last_bits;          // Bits in final partial byte
        logic       no_parity;          // Full last byte without parity
        logic [7:0] last_raw;           // Last byte, bits shifted in at top
        logic       hard_framing_error; // Corrupting framing error
    } rxs_rx_type;

    // Collision report from the bit decoder
    typedef struct packed {
        logic       valid;              // Collision detected pulse
        logic [3:0] full_bytes;         // Complete bytes before collision
        logic [2:0] bits_before;        // Bits of colliding byte before it
        logic       on_parity;          // Collision hit a parity bit
        logic       anticoll_frame;     // Frame is a type-A anticollision cmd
    } rxs_col_type;

endpackage

// >>> verification/rxs_host_model.sv
// Host side model: drives the register port with one-cycle strobes.
// Assumes a single clk_sys domain and read data one cycle after the strobe.
`timescale 1ns/1ps
`default_nettype none

module rxs_host_model (
    input  wire logic       clk_sys,    // System clock
    input  wire logic [7:0] reg_rdata,  // Read data from the bank
    output logic      [7:0] reg_addr,   // Register address
    output logic      [7:0] reg_wdata,  // Write data
    output logic            reg_wr,     // Write strobe
    output logic            reg_rd      // Read strobe
);
    initial begin
        reg_addr  = 8'h00;
        reg_wdata = 8'h00;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
    end

    // Idle bus shows inverted values, never the stale ones
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk_sys);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= v;
        @(posedge clk_sys);
        reg_wr    <= 1'b0;
        reg_addr  <= ~a;
        reg_wdata <= ~v;
    endtask

    // Read strobe lasts one cycle; data is sampled just after the next edge
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd   <= 1'b0;
        reg_addr <= ~a;
        #1 d = reg_rdata;
    endtask
endmodule // rxs_host_model

`default_nettype wire

// >>> verification/rxs_status_regs_tb.sv
// Self-checking bench for the receive status register bank.
// Assumes the design package and host model are compiled first.
`timescale 1ns/1ps
`default_nettype none

module rxs_status_regs_tb;
    typedef struct packed {
        logic [6:0] e;
        logic       dn;
        logic [4:0] sl;
        logic [3:0] st;
        logic [7:0] x;
    } rxs_row_type;

    logic clk_sys, srst, reg_wr, reg_rd, target_irq, hfe;
    logic buf_push, buf_pop, buf_clear;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, lba, d;
    logic [4:0] slots_free;
    logic [3:0] pta_state;
    rxs_pkg::rxs_evt_type evt;
    rxs_pkg::rxs_rx_type  rx;
    rxs_pkg::rxs_col_type col;
    int err_count, num_checks;
    rxs_row_type rows [8] = '{
        '{7'h40, 1'b0, 5'd5, 4'h0, 8'h80}, '{7'h28, 1'b0, 5'd5, 4'h0, 8'h20},
        '{7'h38, 1'b0, 5'd5, 4'h0, 8'h00}, '{7'h06, 1'b1, 5'd5, 4'h0, 8'h10},
        '{7'h01, 1'b0, 5'd5, 4'h0, 8'h08}, '{7'h00, 1'b0, 5'd4, 4'h0, 8'h40},
        '{7'h00, 1'b0, 5'd5, 4'hD, 8'h02}, '{7'h00, 1'b0, 5'd5, 4'h5, 8'h01}};

    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    rxs_host_model u_rxs_host_model (.clk_sys(clk_sys), .reg_rdata(reg_rdata),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd));

    rxs_status_regs #(.BUF_DEPTH(512), .SLOT_W(5)) u_rxs_status_regs (
        .clk_sys(clk_sys), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .evt(evt),
        .slots_free(slots_free), .pta_state(pta_state), .buf_push(buf_push),
        .buf_pop(buf_pop), .buf_clear(buf_clear), .rx(rx), .col(col),
        .target_irq(target_irq), .last_byte_aligned(lba), .hard_framing_error(hfe));

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] v;
        u_rxs_host_model.rd(a, v);
        chk(v, exp);
    endtask

    task automatic bufop(input int n, input logic pu, input logic po);
        repeat (n) begin
            @(posedge clk_sys);
            buf_push <= pu;
            buf_pop  <= po;
        end
        @(posedge clk_sys);
        buf_push <= 1'b0;
        buf_pop  <= 1'b0;
    endtask

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    initial begin
        #100us;
        err_count++;
        wrap_up;
    end

    initial begin
        srst = 1'b1; evt = '0; rx = '0; col = '0; slots_free = 5'd5; pta_state = 4'h0;
        buf_push = 1'b0; buf_pop = 1'b0; buf_clear = 1'b0; err_count = 0; num_checks = 0;
        repeat (8) @(posedge clk_sys);
        srst <= 1'b0;
        @(posedge clk_sys);
        #1 chk({6'h0, target_irq, hfe}, 8'h00);
        chk(lba, 8'h00);
        rchk(8'h1E, 8'h00);
        $display("test reset done");
        // ---------------------------------------------
        // Event table
        // ---------------------------------------------
        foreach (rows[i]) begin
            @(posedge clk_sys);
            evt <= rows[i].e; rx.done <= rows[i].dn;
            slots_free <= rows[i].sl; pta_state <= rows[i].st;
            @(posedge clk_sys);
            evt <= '0; rx.done <= 1'b0; slots_free <= 5'd5; pta_state <= 4'h0;
            #1 chk({7'h0, target_irq}, {7'h0, rows[i].x != 8'h00});
            rchk(8'h1D, rows[i].x);
            rchk(8'h1D, 8'h00);
        end
        $display("test events done");
        // ---------------------------------------------
        // Mask, set during read, unmapped and read-only
        // ---------------------------------------------
        u_rxs_host_model.wr(8'h30, 8'hFF);
        rchk(8'h30, 8'hFB);
        @(posedge clk_sys) evt.high_rate_target_active_event <= 1'b1;
        @(posedge clk_sys) evt.high_rate_target_active_event <= 1'b0;
        #1 chk({7'h0, target_irq}, 8'h00);
        rchk(8'h1D, 8'h08);
        u_rxs_host_model.wr(8'h30, 8'h00);
        fork
            rchk(8'h1D, 8'h00);
            begin
                @(posedge clk_sys) evt.field_wait_timer_event <= 1'b1;
                @(posedge clk_sys) evt.field_wait_timer_event <= 1'b0;
            end
        join
        rchk(8'h1D, 8'h80);
        rchk(8'h40, 8'h00);
        u_rxs_host_model.wr(8'h1E, 8'h55);
        rchk(8'h1E, 8'h00);
        $display("test access done");
        // ---------------------------------------------
        // Buffer count and sticky flags
        // ---------------------------------------------
        bufop(259, 1'b1, 1'b0);
        rchk(8'h1E, 8'h03);
        rchk(8'h1F, 8'h40);
        bufop(253, 1'b1, 1'b0);
        rchk(8'h1E, 8'h00);
        rchk(8'h1F, 8'h80);
        bufop(2, 1'b1, 1'b1);
        rchk(8'h1F, 8'h80);
        bufop(1, 1'b1, 1'b0);
        rchk(8'h1F, 8'h90);
        @(posedge clk_sys) buf_clear <= 1'b1;
        @(posedge clk_sys) buf_clear <= 1'b0;
        bufop(1, 1'b0, 1'b1);
        rchk(8'h1F, 8'h20);
        rchk(8'h1E, 8'h00);
        @(posedge clk_sys) buf_clear <= 1'b1;
        @(posedge clk_sys) buf_clear <= 1'b0;
        $display("test buffer done");
        // ---------------------------------------------
        // Last byte, framing error, collision
        // ---------------------------------------------
        @(posedge clk_sys) rx <= '{1'b0, 1'b1, 3'd3, 1'b0, 8'hA0, 1'b0};
        @(posedge clk_sys) rx <= '0;
        #1 chk(lba, 8'h05);
        rchk(8'h1F, 8'h06);
        @(posedge clk_sys) rx <= '{1'b0, 1'b1, 3'd0, 1'b1, 8'h3C, 1'b0};
        @(posedge clk_sys) rx <= '0;
        #1 chk(lba, 8'h3C);
        rchk(8'h1F, 8'h01);
        @(posedge clk_sys) rx.hard_framing_error <= 1'b1;
        @(posedge clk_sys) rx.hard_framing_error <= 1'b0;
        #1 chk({7'h0, hfe}, 8'h01);
        rchk(8'h31, 8'h10);
        rchk(8'h31, 8'h00);
        fork
            rchk(8'h31, 8'h00);
            begin
                @(posedge clk_sys) rx.hard_framing_error <= 1'b1;
                @(posedge clk_sys) rx.hard_framing_error <= 1'b0;
            end
        join
        rchk(8'h31, 8'h10);
        @(posedge clk_sys) rx.start <= 1'b1;
        @(posedge clk_sys) begin
            rx.start <= 1'b0;
            col <= '{1'b1, 4'd3, 3'd5, 1'b0, 1'b1};
        end
        @(posedge clk_sys) col <= '{1'b1, 4'd9, 3'd1, 1'b1, 1'b1};
        @(posedge clk_sys) col <= '0;
        rchk(8'h20, 8'h3A);
        @(posedge clk_sys) rx.start <= 1'b1;
        @(posedge clk_sys) begin
            rx.start <= 1'b0;
            col <= '{1'b1, 4'd7, 3'd7, 1'b1, 1'b0};
        end
        @(posedge clk_sys) col <= '0;
        rchk(8'h20, 8'h3A);
        @(posedge clk_sys) rx.start <= 1'b1;
        @(posedge clk_sys) begin
            rx.start <= 1'b0;
            col <= '{1'b1, 4'd1, 3'd2, 1'b1, 1'b1};
        end
        @(posedge clk_sys) col <= '0;
        rchk(8'h20, 8'h15);
        $display("test frame done");
        wrap_up;
    end
endmodule // rxs_status_regs_tb

`default_nettype wire
